// file: irvm_pkg.sv
/*
  Shared constants for the interrupt request and vector mapping block:
  source indices, vector numbers, vector addresses and reset values.
  Assumes one system clock and a synchronous active-high reset.
*/
package irvm_pkg;

  localparam int NUM_SRC = 23;
  localparam int SRC_W = 5;
  localparam int VEC_W = 6;
  localparam int ADDR_W = 8;

  // maskable source indices, ordered so that a lower index never has a
  // higher vector than a higher index
  localparam int SRC_LEVEL_MON = 0;
  localparam int SRC_RTC_OVF = 1;
  localparam int SRC_RTC_CMP = 2;
  localparam int SRC_PERIODIC = 3;
  localparam int SRC_GLUE = 4;
  localparam int SRC_PORT_FIRST = 5;
  localparam int SRC_TMRA_OVF = 6;
  localparam int SRC_TMRA_UNF = 7;
  localparam int SRC_TMRA_CMP0 = 8;
  localparam int SRC_TMRA_CMP1 = 9;
  localparam int SRC_TMRA_CMP2 = 10;
  localparam int SRC_TMRB0_CAPT = 11;
  localparam int SRC_TMRB1_CAPT = 12;
  localparam int SRC_TW_TARGET = 13;
  localparam int SRC_TW_CTRL = 14;
  localparam int SRC_SER_PERIPH = 15;
  localparam int SRC_SER0_RXC = 16;
  localparam int SRC_SER0_DRE = 17;
  localparam int SRC_SER0_TXC = 18;
  localparam int SRC_PORT_FOURTH = 19;
  localparam int SRC_COMPARE = 20;
  localparam int SRC_CONV_RES = 21;
  localparam int SRC_CONV_WIN = 22;

  localparam logic [VEC_W-1:0] VEC_RESET = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h01;
  localparam logic [VEC_W-1:0] VEC_LEVEL_MON = 6'h02;
  localparam logic [VEC_W-1:0] VEC_RTC = 6'h03;
  localparam logic [VEC_W-1:0] VEC_PERIODIC = 6'h04;
  localparam logic [VEC_W-1:0] VEC_GLUE = 6'h05;
  localparam logic [VEC_W-1:0] VEC_PORT_FIRST = 6'h06;
  localparam logic [VEC_W-1:0] VEC_TMRA_OVF = 6'h07;
  localparam logic [VEC_W-1:0] VEC_TMRA_UNF = 6'h08;
  localparam logic [VEC_W-1:0] VEC_TMRA_CMP0 = 6'h09;
  localparam logic [VEC_W-1:0] VEC_TMRA_CMP1 = 6'h0a;
  localparam logic [VEC_W-1:0] VEC_TMRA_CMP2 = 6'h0b;
  localparam logic [VEC_W-1:0] VEC_TMRB0_CAPT = 6'h0c;
  localparam logic [VEC_W-1:0] VEC_TMRB1_CAPT = 6'h0d;
  localparam logic [VEC_W-1:0] VEC_TW_TARGET = 6'h0e;
  localparam logic [VEC_W-1:0] VEC_TW_CTRL = 6'h0f;
  localparam logic [VEC_W-1:0] VEC_SER_PERIPH = 6'h10;
  localparam logic [VEC_W-1:0] VEC_SER0_RXC = 6'h11;
  localparam logic [VEC_W-1:0] VEC_SER0_DRE = 6'h12;
  localparam logic [VEC_W-1:0] VEC_SER0_TXC = 6'h13;
  localparam logic [VEC_W-1:0] VEC_PORT_FOURTH = 6'h14;
  localparam logic [VEC_W-1:0] VEC_COMPARE = 6'h15;
  localparam logic [VEC_W-1:0] VEC_CONV_RES = 6'h16;
  localparam logic [VEC_W-1:0] VEC_CONV_WIN = 6'h17;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_NMI = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_MON = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RTC = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_PERIODIC = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_GLUE = 8'h0a;
  localparam logic [ADDR_W-1:0] ADDR_PORT_FIRST = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TMRA_OVF = 8'h0e;
  localparam logic [ADDR_W-1:0] ADDR_TMRA_UNF = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TMRA_CMP0 = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_TMRA_CMP1 = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_TMRA_CMP2 = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_TMRB0_CAPT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_TMRB1_CAPT = 8'h1a;
  localparam logic [ADDR_W-1:0] ADDR_TW_TARGET = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_TW_CTRL = 8'h1e;
  localparam logic [ADDR_W-1:0] ADDR_SER_PERIPH = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_SER0_RXC = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_SER0_DRE = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_SER0_TXC = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_PORT_FOURTH = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE = 8'h2a;
  localparam logic [ADDR_W-1:0] ADDR_CONV_RES = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_CONV_WIN = 8'h2e;

  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 23'h000000;

  // each vector belongs to one peripheral; the counter's two sources share
  function automatic logic [VEC_W-1:0] src_to_vec(input logic [SRC_W-1:0] s);
    logic [VEC_W-1:0] v;
    v = VEC_RESET;
    case (s)
      5'h00: v = VEC_LEVEL_MON;
      5'h01, 5'h02: v = VEC_RTC;
      5'h03: v = VEC_PERIODIC;
      5'h04: v = VEC_GLUE;
      5'h05: v = VEC_PORT_FIRST;
      5'h06: v = VEC_TMRA_OVF;
      5'h07: v = VEC_TMRA_UNF;
      5'h08: v = VEC_TMRA_CMP0;
      5'h09: v = VEC_TMRA_CMP1;
      5'h0a: v = VEC_TMRA_CMP2;
      5'h0b: v = VEC_TMRB0_CAPT;
      5'h0c: v = VEC_TMRB1_CAPT;
      5'h0d: v = VEC_TW_TARGET;
      5'h0e: v = VEC_TW_CTRL;
      5'h0f: v = VEC_SER_PERIPH;
      5'h10: v = VEC_SER0_RXC;
      5'h11: v = VEC_SER0_DRE;
      5'h12: v = VEC_SER0_TXC;
      5'h13: v = VEC_PORT_FOURTH;
      5'h14: v = VEC_COMPARE;
      5'h15: v = VEC_CONV_RES;
      5'h16: v = VEC_CONV_WIN;
      default: v = VEC_RESET;
    endcase
    return v;
  endfunction : src_to_vec

  // vectors are two address units apart
  function automatic logic [ADDR_W-1:0] vec_addr(input logic [VEC_W-1:0] v);
    return {1'b0, v, 1'b0};
  endfunction : vec_addr

endpackage : irvm_pkg

// file: irvm_flag_bank.sv
/*
  Bank of sticky interrupt flags, one per maskable source.
  Assumes set and clear strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
module irvm_flag_bank
  import irvm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // strobes
  input wire logic [NUM_SRC-1:0] set_in,
  input wire logic [NUM_SRC-1:0] clr_in,
  // state
  output logic [NUM_SRC-1:0] flag_out
);

  typedef struct packed {
    logic [NUM_SRC-1:0] flag;
  } irvm_fb_state_t;

  irvm_fb_state_t s_reg;
  irvm_fb_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    // set beats a clear landing in the same cycle
    s_next.flag = (s_reg.flag & ~clr_in) | set_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      s_reg.flag <= FLAGS_RESET;
    else
      s_reg <= s_next;
  end

  assign flag_out = s_reg.flag;

endmodule : irvm_flag_bank

// file: irvm_prio_enc.sv
/*
  Lowest-index finder over the live request vector.
  Assumes source index order follows vector order.
*/
`timescale 1ns/1ps
module irvm_prio_enc
  import irvm_pkg::*;
(
  // requests
  input wire logic [NUM_SRC-1:0] req_in,
  // result
  output logic found_out,
  output logic [SRC_W-1:0] idx_out
);

  always_comb
  begin
    found_out = 1'b0;
    idx_out = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        found_out = 1'b1;
        idx_out = SRC_W'(i);
      end
    end
  end

endmodule : irvm_prio_enc

// file: irvm_ctrl.sv
/*
  Interrupt request generation and vector mapping for the processor core.
  Peripherals drive one-cycle condition strobes and flag clears on the
  system clock; enables and the global enable are plain level inputs.
*/
// Summary of operation
// - Each vector belongs to one peripheral, which may merge its sources.
// - A peripheral condition sets that source's sticky flag.
// - A per-source enable bit turns each source on or off.
// - A source starts a request only while its enable and its flag are both set.
// - A taken request lasts until its flag clears, whatever the enable.
// - Nothing maskable reaches the core unless the global enable is set.
// - Reset sits at vector 0 (0x00); the checksum NMI at vector 1 (0x02).
// - The supply level monitor uses vector 2 at 0x04.
// - Counter overflow and compare share vector 3; periodic uses vector 4.
// - Glue logic uses vector 5, the first pin port vector 6.
// - Timer A overflow, underflow and compares 0-2 use vectors 7 to 11.
// - Timer B captures use 12, 13; two-wire 14, 15; serial periph 16.
// - Serial port 0 receive, data empty, transmit use vectors 17 to 19.
// - Fourth port 20, comparator 21, converter result 22, window 23.
`timescale 1ns/1ps
module irvm_ctrl
  import irvm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // peripheral condition strobes
  input wire logic level_mon_cond_in,
  input wire logic rtc_ovf_cond_in,
  input wire logic rtc_cmp_cond_in,
  input wire logic periodic_cond_in,
  input wire logic glue_cond_in,
  input wire logic port_first_cond_in,
  input wire logic tmra_ovf_cond_in,
  input wire logic tmra_unf_cond_in,
  input wire logic tmra_cmp0_cond_in,
  input wire logic tmra_cmp1_cond_in,
  input wire logic tmra_cmp2_cond_in,
  input wire logic tmrb0_capt_cond_in,
  input wire logic tmrb1_capt_cond_in,
  input wire logic tw_target_cond_in,
  input wire logic tw_ctrl_cond_in,
  input wire logic ser_periph_cond_in,
  input wire logic ser0_rxc_cond_in,
  input wire logic ser0_dre_cond_in,
  input wire logic ser0_txc_cond_in,
  input wire logic port_fourth_cond_in,
  input wire logic compare_cond_in,
  input wire logic conv_res_cond_in,
  input wire logic conv_win_cond_in,
  input wire logic crc_nmi_cond_in,
  // flag clears and enables from software-facing peripheral logic
  input wire logic [NUM_SRC-1:0] flag_clear_in,
  input wire logic nmi_clear_in,
  input wire logic [NUM_SRC-1:0] src_enable_in,
  input wire logic global_int_en_in,
  // to the processor core
  output logic irq_req_out,
  output logic [VEC_W-1:0] irq_vector_out,
  output logic [ADDR_W-1:0] irq_addr_out,
  output logic nmi_pending_out,
  output logic reset_entry_out,
  // flag state for read-back
  output logic [NUM_SRC-1:0] irq_flags_out
);

  typedef struct packed {
    logic [NUM_SRC-1:0] req;
    logic nmi_flag;
    logic irq_req;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W-1:0] addr;
    logic rst_entry;
  } irvm_state_t;

  irvm_state_t s_reg;
  irvm_state_t s_next;

  logic [NUM_SRC-1:0] src_event_w;
  logic [NUM_SRC-1:0] flag_w;
  logic [NUM_SRC-1:0] live_req_w;
  logic [NUM_SRC-1:0] fwd_w;
  logic found_w;
  logic [SRC_W-1:0] idx_w;

  // source order matches vector order, which the encoder relies on
  assign src_event_w = {
    conv_win_cond_in,
    conv_res_cond_in,
    compare_cond_in,
    port_fourth_cond_in,
    ser0_txc_cond_in,
    ser0_dre_cond_in,
    ser0_rxc_cond_in,
    ser_periph_cond_in,
    tw_ctrl_cond_in,
    tw_target_cond_in,
    tmrb1_capt_cond_in,
    tmrb0_capt_cond_in,
    tmra_cmp2_cond_in,
    tmra_cmp1_cond_in,
    tmra_cmp0_cond_in,
    tmra_unf_cond_in,
    tmra_ovf_cond_in,
    port_first_cond_in,
    glue_cond_in,
    periodic_cond_in,
    rtc_cmp_cond_in,
    rtc_ovf_cond_in,
    level_mon_cond_in
  };

  irvm_flag_bank u_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(src_event_w),
    .clr_in(flag_clear_in),
    .flag_out(flag_w)
  );

  // a taken request survives a dropped enable; only the flag ends it
  assign live_req_w = (flag_w & src_enable_in)
                    | (s_reg.req & flag_w);
  assign fwd_w = live_req_w & {NUM_SRC{global_int_en_in}};

  irvm_prio_enc u_enc (
    .req_in(fwd_w),
    .found_out(found_w),
    .idx_out(idx_w)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.req = live_req_w;
    s_next.rst_entry = 1'b0;
    // nmi: set wins over clear, no enable of any kind applies
    s_next.nmi_flag = (s_reg.nmi_flag & ~nmi_clear_in)
                    | crc_nmi_cond_in;
    if (s_reg.nmi_flag)
    begin
      s_next.irq_req = 1'b1;
      s_next.vec = VEC_NMI;
    end
    else if (found_w)
    begin
      s_next.irq_req = 1'b1;
      s_next.vec = src_to_vec(idx_w);
    end
    else
    begin
      s_next.irq_req = 1'b0;
      s_next.vec = VEC_RESET;
    end
    s_next.addr = vec_addr(s_next.vec);
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      s_reg.req <= FLAGS_RESET;
      s_reg.nmi_flag <= 1'b0;
      s_reg.irq_req <= 1'b0;
      s_reg.vec <= VEC_RESET;
      s_reg.addr <= ADDR_RESET;
      s_reg.rst_entry <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign irq_req_out = s_reg.irq_req;
  assign irq_vector_out = s_reg.vec;
  assign irq_addr_out = s_reg.addr;
  assign nmi_pending_out = s_reg.nmi_flag;
  assign reset_entry_out = s_reg.rst_entry;
  assign irq_flags_out = flag_w;

  // helpers read only by the checks below
  logic [NUM_SRC-1:0] held_w;
  logic lm_win_w;
  logic rtc_cmp_only_w;
  logic quiet_w;
  assign held_w = s_reg.req & flag_w;
  assign lm_win_w = fwd_w[SRC_LEVEL_MON] & ~s_reg.nmi_flag;
  assign rtc_cmp_only_w = fwd_w[SRC_RTC_CMP] & ~s_reg.nmi_flag
                        & ~(|fwd_w[SRC_RTC_CMP-1:0]);
  assign quiet_w = ~s_reg.nmi_flag & ~(|(flag_w & src_enable_in))
                 & ~(|s_reg.req);
  // one forwarded source and no alarm: the vector is fixed by the table
  logic solo_w;
  logic [NUM_SRC-1:0] idle_w;
  assign solo_w = ~s_reg.nmi_flag & (|fwd_w)
                & ~(|(fwd_w & (fwd_w - NUM_SRC'(1))));
  assign idle_w = flag_w & ~src_enable_in & ~s_reg.req;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  flag_set_a: assert property (
    |src_event_w |=> ((flag_w & $past(src_event_w)) == $past(src_event_w)))
    else $error("condition did not set its flag");

  enable_gate_a: assert property (
    quiet_w |=> !irq_req_out)
    else $error("request without enabled flag");

  request_hold_a: assert property (
    |held_w |=> ((s_reg.req & $past(held_w)) == $past(held_w)))
    else $error("request dropped while flag still set");

  global_gate_a: assert property (
    (!global_int_en_in && !s_reg.nmi_flag) |=> !irq_req_out)
    else $error("request forwarded with global enable off");

  nmi_bypass_a: assert property (
    crc_nmi_cond_in |=> nmi_pending_out ##1 (irq_req_out
      && irq_vector_out == VEC_NMI && irq_addr_out == ADDR_NMI))
    else $error("nmi not presented at vector 1");

  // the default disable would switch this check off exactly when it applies
  reset_entry_a: assert property (
    @(posedge clk_in) disable iff (1'b0)
    sys_rst_in |=> (irq_vector_out == VEC_RESET
      && irq_addr_out == ADDR_RESET && !irq_req_out && reset_entry_out))
    else $error("reset entry not at vector 0");

  level_mon_a: assert property (
    lm_win_w |=> (irq_vector_out == VEC_LEVEL_MON
      && irq_addr_out == ADDR_LEVEL_MON))
    else $error("level monitor not at vector 2");

  rtc_merge_a: assert property (
    rtc_cmp_only_w |=> (irq_vector_out == VEC_RTC
      && irq_addr_out == ADDR_RTC))
    else $error("counter compare not at vector 3");

  last_vector_a: assert property (
    (fwd_w == 23'h400000 && !s_reg.nmi_flag) |=>
      (irq_vector_out == VEC_CONV_WIN && irq_addr_out == ADDR_CONV_WIN))
    else $error("converter window not at vector 23");

  lowest_first_a: assert property (
    (found_w && !s_reg.nmi_flag) |=> (irq_req_out
      && irq_vector_out <= src_to_vec(SRC_W'(SRC_CONV_WIN))
      && irq_vector_out == $past(src_to_vec(idx_w))))
    else $error("not the lowest pending vector");

  enc_lowest_a: assert property (
    found_w |-> (fwd_w[idx_w]
      && (fwd_w & ((NUM_SRC'(1) << idx_w) - NUM_SRC'(1))) == '0))
    else $error("encoder skipped a lower pending source");

  disabled_src_a: assert property (
    |idle_w |=> ((s_reg.req & $past(idle_w)) == '0))
    else $error("disabled source latched a request");

  nmi_hold_a: assert property (
    (nmi_pending_out && !nmi_clear_in) |=> nmi_pending_out)
    else $error("checksum alarm dropped without a clear");

  rtc_ovf_a: assert property (
    (solo_w && fwd_w[SRC_RTC_OVF]) |=> (irq_vector_out == VEC_RTC
      && irq_addr_out == ADDR_RTC))
    else $error("counter overflow not at vector 3");

  periodic_vec_a: assert property (
    (solo_w && fwd_w[SRC_PERIODIC]) |=> (irq_vector_out == VEC_PERIODIC
      && irq_addr_out == ADDR_PERIODIC))
    else $error("periodic source not at vector 4");

  glue_vec_a: assert property (
    (solo_w && fwd_w[SRC_GLUE]) |=> (irq_vector_out == VEC_GLUE
      && irq_addr_out == ADDR_GLUE))
    else $error("glue logic not at vector 5");

  port_first_a: assert property (
    (solo_w && fwd_w[SRC_PORT_FIRST]) |=> (irq_vector_out == VEC_PORT_FIRST
      && irq_addr_out == ADDR_PORT_FIRST))
    else $error("first pin port not at vector 6");

  tmra_ovf_a: assert property (
    (solo_w && fwd_w[SRC_TMRA_OVF]) |=> (irq_vector_out == VEC_TMRA_OVF
      && irq_addr_out == ADDR_TMRA_OVF))
    else $error("timer a overflow not at vector 7");

  tmra_cmp2_a: assert property (
    (solo_w && fwd_w[SRC_TMRA_CMP2]) |=> (irq_vector_out == VEC_TMRA_CMP2
      && irq_addr_out == ADDR_TMRA_CMP2))
    else $error("timer a compare 2 not at vector 11");

  tmrb1_capt_a: assert property (
    (solo_w && fwd_w[SRC_TMRB1_CAPT]) |=> (irq_vector_out == VEC_TMRB1_CAPT
      && irq_addr_out == ADDR_TMRB1_CAPT))
    else $error("timer b1 capture not at vector 13");

  ser_periph_a: assert property (
    (solo_w && fwd_w[SRC_SER_PERIPH]) |=> (irq_vector_out == VEC_SER_PERIPH
      && irq_addr_out == ADDR_SER_PERIPH))
    else $error("serial peripheral not at vector 16");

  ser0_txc_a: assert property (
    (solo_w && fwd_w[SRC_SER0_TXC]) |=> (irq_vector_out == VEC_SER0_TXC
      && irq_addr_out == ADDR_SER0_TXC))
    else $error("serial transmit complete not at vector 19");

  conv_res_a: assert property (
    (solo_w && fwd_w[SRC_CONV_RES]) |=> (irq_vector_out == VEC_CONV_RES
      && irq_addr_out == ADDR_CONV_RES))
    else $error("converter result not at vector 22");

  nmi_seen_c: cover property (crc_nmi_cond_in ##2 irq_req_out);
  two_pending_c: cover property (fwd_w[SRC_PORT_FIRST] && fwd_w[SRC_CONV_WIN]);
  gated_c: cover property (!global_int_en_in && |live_req_w);
  held_c: cover property (s_reg.req[SRC_GLUE] && !src_enable_in[SRC_GLUE]);

endmodule : irvm_ctrl

// file: irvm_periph_model.sv
/*
  Peripheral-side model: one-cycle condition strobes and flag clears.
  Assumes the bench calls strobe; it drives only off the falling edge.
*/
`timescale 1ns/1ps
module irvm_periph_model
  import irvm_pkg::*;
(
  // clock
  input wire logic clk_in,
  // strobes to the controller
  output logic [NUM_SRC-1:0] cond_out,
  output logic crc_out,
  output logic [NUM_SRC-1:0] clr_out,
  output logic nmi_clr_out
);
  initial
  begin
    cond_out = '0;
    crc_out = 1'b0;
    clr_out = '0;
    nmi_clr_out = 1'b0;
  end

  // strobes last one cycle, so each call gives each strobed source exactly one condition
  task automatic strobe(input logic [NUM_SRC-1:0] c,
    input logic [NUM_SRC-1:0] k, input logic n, input logic nc);
    @(negedge clk_in);
    cond_out = c;
    clr_out = k;
    crc_out = n;
    nmi_clr_out = nc;
    @(negedge clk_in);
    cond_out = '0;
    clr_out = '0;
    crc_out = 1'b0;
    nmi_clr_out = 1'b0;
  endtask : strobe
endmodule : irvm_periph_model

// file: irvm_ctrl_tb.sv
/*
  Self-checking bench for the request and vector mapping controller.
  Assumes a 100 MHz clock; enables are driven here, strobes by the model.
*/
`timescale 1ns/1ps
module irvm_ctrl_tb;
  import irvm_pkg::*;
  logic clk_in, sys_rst_in, glb, crc, nc, req, nmi_p, rst_e;
  logic [NUM_SRC-1:0] en, c, k, flags;
  logic [VEC_W-1:0] vec;
  logic [ADDR_W-1:0] addr;
  int n_fail = 0;
  int num_checks = 0;

  irvm_periph_model P (.clk_in(clk_in), .cond_out(c), .crc_out(crc),
    .clr_out(k), .nmi_clr_out(nc));

  irvm_ctrl DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .level_mon_cond_in(c[0]), .rtc_ovf_cond_in(c[1]),
    .rtc_cmp_cond_in(c[2]), .periodic_cond_in(c[3]), .glue_cond_in(c[4]),
    .port_first_cond_in(c[5]), .tmra_ovf_cond_in(c[6]),
    .tmra_unf_cond_in(c[7]), .tmra_cmp0_cond_in(c[8]),
    .tmra_cmp1_cond_in(c[9]), .tmra_cmp2_cond_in(c[10]),
    .tmrb0_capt_cond_in(c[11]), .tmrb1_capt_cond_in(c[12]),
    .tw_target_cond_in(c[13]), .tw_ctrl_cond_in(c[14]),
    .ser_periph_cond_in(c[15]), .ser0_rxc_cond_in(c[16]),
    .ser0_dre_cond_in(c[17]), .ser0_txc_cond_in(c[18]),
    .port_fourth_cond_in(c[19]), .compare_cond_in(c[20]),
    .conv_res_cond_in(c[21]), .conv_win_cond_in(c[22]),
    .crc_nmi_cond_in(crc), .flag_clear_in(k), .nmi_clear_in(nc),
    .src_enable_in(en), .global_int_en_in(glb), .irq_req_out(req),
    .irq_vector_out(vec), .irq_addr_out(addr), .nmi_pending_out(nmi_p),
    .reset_entry_out(rst_e), .irq_flags_out(flags));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt

  // request state with the address expected at twice the vector
  task automatic chk_req(input logic r, input logic [VEC_W-1:0] v);
    chk("req", 32'(req), 32'(r));
    chk("vector", 32'(vec), 32'(v));
    chk("addr", 32'(addr), 32'(v) * 2);
  endtask : chk_req

  function automatic logic [VEC_W-1:0] vec_of(input int i);
    if (i == 0)
      return 6'h02;
    if (i <= 2)
      return 6'h03;
    return VEC_W'(i + 1);
  endfunction : vec_of

  task automatic t_reset;
    repeat (5) @(negedge clk_in);
    chk("entry", 32'(rst_e), 32'h1);
    chk_req(1'b0, 6'h00);
    chk("flags", 32'(flags), 32'h0);
    sys_rst_in = 1'b0;
    wt(1);
    chk("entry", 32'(rst_e), 32'h0);
  endtask : t_reset

  task automatic t_map;
    en = '1;
    glb = 1'b1;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      P.strobe(NUM_SRC'(1) << i, '0, 1'b0, 1'b0);
      wt(2);
      chk("flags", 32'(flags), 32'(1) << i);
      chk_req(1'b1, vec_of(i));
      P.strobe('0, NUM_SRC'(1) << i, 1'b0, 1'b0);
      wt(2);
      chk_req(1'b0, 6'h00);
    end
  endtask : t_map

  task automatic t_mask;
    en = '0;
    P.strobe(NUM_SRC'(1) << 4, '0, 1'b0, 1'b0);
    wt(2);
    chk("flags", 32'(flags), 32'h10);
    chk_req(1'b0, 6'h00);
    en[4] = 1'b1;
    wt(2);
    chk_req(1'b1, 6'h05);
    glb = 1'b0;
    wt(2);
    chk_req(1'b0, 6'h00);
    glb = 1'b1;
    wt(2);
    chk_req(1'b1, 6'h05);
    en[4] = 1'b0;
    wt(2);
    chk_req(1'b1, 6'h05);
    P.strobe('0, NUM_SRC'(1) << 4, 1'b0, 1'b0);
    wt(2);
    chk_req(1'b0, 6'h00);
  endtask : t_mask

  // two sources pending together, then the checksum alarm over the one left
  task automatic t_prio;
    en = '1;
    P.strobe((NUM_SRC'(1) << 22) | (NUM_SRC'(1) << 5), '0, 1'b0, 1'b0);
    wt(2);
    chk_req(1'b1, 6'h06);
    P.strobe('0, NUM_SRC'(1) << 5, 1'b0, 1'b0);
    wt(2);
    chk_req(1'b1, 6'h17);
    glb = 1'b0;
    P.strobe('0, '0, 1'b1, 1'b0);
    wt(2);
    chk("nmi", 32'(nmi_p), 32'h1);
    chk_req(1'b1, 6'h01);
    glb = 1'b1;
    wt(2);
    chk_req(1'b1, 6'h01);
    P.strobe('0, '0, 1'b0, 1'b1);
    wt(2);
    chk_req(1'b1, 6'h17);
    P.strobe('0, NUM_SRC'(1) << 22, 1'b0, 1'b0);
    wt(2);
    chk_req(1'b0, 6'h00);
  endtask : t_prio

  // a reset in mid-run drops pending flags and the checksum alarm
  task automatic t_rerun;
    P.strobe(NUM_SRC'(1) << 3, '0, 1'b1, 1'b0);
    wt(2);
    chk_req(1'b1, 6'h01);
    sys_rst_in = 1'b1;
    wt(2);
    chk("entry", 32'(rst_e), 32'h1);
    chk("flags", 32'(flags), 32'h0);
    chk("nmi", 32'(nmi_p), 32'h0);
    chk_req(1'b0, 6'h00);
    sys_rst_in = 1'b0;
    wt(2);
    chk("entry", 32'(rst_e), 32'h0);
    chk_req(1'b0, 6'h00);
  endtask : t_rerun

  initial
  begin
    #50000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    sys_rst_in = 1'b1;
    glb = 1'b0;
    en = '0;
    t_reset();
    t_map();
    t_mask();
    t_prio();
    t_rerun();
    complete_run();
  end
endmodule : irvm_ctrl_tb
